// [include/frcd_pkg.sv]
// constants, enumerations and carriers of the flash command decoder
// assumes a 100 MHz core clock and a host-driven serial clock
package frcd_pkg;
  // opcodes
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] OP_CLEAR_LEGACY = 8'h30;
  localparam logic [7:0] OP_CLEAR_ALT = 8'h82;
  localparam logic [7:0] OP_ECC_READ = 8'h19;
  localparam logic [7:0] OP_ECC_READ_WIDE = 8'h18;
  localparam logic [7:0] OP_NV_PROGRAM = 8'h43;
  localparam logic [7:0] OP_VOL_WRITE = 8'h4a;
  localparam logic [7:0] OP_PATTERN_READ = 8'h41;
  localparam logic [7:0] OP_WIDE_ENTER = 8'hb7;
  localparam logic [7:0] OP_PARAM_READ = 8'h5a;
  // volatile status one field positions
  localparam int ST1_BUSY = 0;
  localparam int ST1_LATCH = 1;
  localparam int ST1_ERASE_FAIL = 5;
  localparam int ST1_PROG_FAIL = 6;
  // reset values
  localparam logic [7:0] STATUS_ONE_RESET = 8'h00;
  localparam logic [7:0] PATTERN_RESET = 8'h00;
  // link geometry
  localparam logic [5:0] BYTE_BITS = 6'h08;
  localparam logic [5:0] ADDR_BITS_NARROW = 6'h18;
  localparam logic [5:0] ADDR_BITS_WIDE = 6'h20;
  localparam logic [3:0] ECC_LAST_BYTE = 4'hf;
  localparam logic [7:0] OE_SINGLE = 8'h22;
  localparam logic [7:0] OE_QUAD = 8'hff;
  // self-timed pattern program, a least time
  localparam int CORE_CLK_MHZ = 100;
  localparam int NV_PROG_NS = 2000;
  localparam int NV_PROG_CYCLES = (NV_PROG_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int NV_TIMER_W = 8;

  typedef enum logic [2:0] {
    ACT_NONE = 3'b000,
    ACT_LATCH_SET = 3'b001,
    ACT_LATCH_CLEAR = 3'b010,
    ACT_CLEAR = 3'b011,
    ACT_RESUME = 3'b100,
    ACT_WIDE = 3'b101,
    ACT_VOL_WRITE = 3'b110,
    ACT_NV_PROGRAM = 3'b111
  } frcd_act_t;

  typedef enum logic [2:0] {
    LS_CMD = 3'b000,
    LS_ADDR = 3'b001,
    LS_DUMMY = 3'b010,
    LS_OUT = 3'b011,
    LS_DATA = 3'b100,
    LS_END = 3'b101,
    LS_IGNORE = 3'b110
  } frcd_lstate_t;

  typedef enum logic [0:0] {
    CS_IDLE = 1'b0,
    CS_PROG = 1'b1
  } frcd_cstate_t;

  typedef struct packed {
    frcd_act_t act;
    logic [7:0] data;
  } frcd_frame_t;

  typedef struct packed {
    logic [7:0] pattern;
    logic [7:0] ecc;
    logic wide;
    logic quad;
    logic resume;
    logic [3:0] latency;
  } frcd_link_cfg_t;
endpackage

// [src/frcd_sync.sv]
// two flip-flop synchroniser bank
// assumes the input is a level, or a word that holds still while it settles
`timescale 1ns/100ps
`default_nettype none
module frcd_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= INIT;
      q <= INIT;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// [src/frcd_decoder.sv]
// command decoder: serial frame decode on the link clock, status and
// configuration state on the core clock
// assumes the host keeps chip select high for at least four core clocks
//
// How it works
// - latch-set opcode sets write latch
// - writes need latch; host sets it first
// - latch commands end exactly after opcode
// - opcode on lane 0, or nibbles on lanes 0-3
// - latch-clear opcode clears write latch
// - latch-clear ignored while busy
// - clear-status resets both fail flags
// - clear-status needs no latch, keeps latch
// - legacy clear may become resume
// - ecc read: address, then latency dummies
// - ecc byte sent sixteen times per unit
// - ecc address width follows opcode, mode
// - nv program: latch, one byte, exact end
// - nv program self-timed, busy, may fail
// - nv program end clears latch
// - volatile pattern written at once
// - pattern shifted out, repeated per byte
// - wide-enter opcode sets address length
// - parameter read always three address bytes
// - only reset leaves wide address mode
// - busy is status bit zero
`timescale 1ns/100ps
`default_nettype none
module frcd_decoder (
  // core clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // serial link
  input wire logic link_sclk,
  input wire logic link_cs_n,
  input wire logic [7:0] link_io_in,
  output logic [7:0] link_io_out,
  output logic [7:0] link_io_oe,
  // configuration
  input wire logic four_lane_command_mode,
  input wire logic legacy_clear_is_resume,
  input wire logic [3:0] read_latency,
  input wire logic soft_reset,
  // neighbouring engines
  input wire logic ext_busy,
  input wire logic ext_prog_fail_set,
  input wire logic ext_erase_fail_set,
  input wire logic nv_prog_fail,
  input wire logic [7:0] ecc_unit_status,
  // status and results
  output logic [7:0] volatile_status_one,
  output logic wide_address_mode,
  output logic [7:0] vol_pattern_register,
  output logic [7:0] nv_pattern_register,
  output logic resume_req,
  output logic [27:0] ecc_unit_index
);
  import frcd_pkg::*;

  function automatic frcd_act_t act_of(input logic [7:0] op,
                                       input logic resume);
    case (op)
      OP_LATCH_SET: act_of = ACT_LATCH_SET;
      OP_LATCH_CLEAR: act_of = ACT_LATCH_CLEAR;
      OP_CLEAR_LEGACY: act_of = resume ? ACT_RESUME : ACT_CLEAR;
      OP_CLEAR_ALT: act_of = ACT_CLEAR;
      OP_WIDE_ENTER: act_of = ACT_WIDE;
      OP_VOL_WRITE: act_of = ACT_VOL_WRITE;
      OP_NV_PROGRAM: act_of = ACT_NV_PROGRAM;
      default: act_of = ACT_NONE;
    endcase
  endfunction

  function automatic logic [5:0] addr_bits(input logic [7:0] op,
                                           input logic wide);
    if (op == OP_ECC_READ_WIDE)
      addr_bits = ADDR_BITS_WIDE;
    else if (op == OP_PARAM_READ)
      addr_bits = ADDR_BITS_NARROW;
    else
      addr_bits = wide ? ADDR_BITS_WIDE : ADDR_BITS_NARROW;
  endfunction

  // ---------------- link domain ----------------
  // chip select high ends the frame and clears the frame machine, so
  // nothing here counts on a clock edge outside a frame
  wire link_rst = rst | link_cs_n;
  frcd_link_cfg_t cfg_l;
  frcd_link_cfg_t cfg_core;
  frcd_lstate_t ls_reg;
  frcd_lstate_t ls_next;
  frcd_frame_t frame_reg;
  frcd_frame_t frame_next;
  logic [5:0] cnt_reg;
  logic [31:0] sh_reg;
  logic [7:0] op_reg;
  logic [2:0] obit_reg;
  logic [3:0] obyte_reg;

  // config words settle within two link edges of the frame; a change of
  // lane mode must precede the frame by one whole earlier frame
  assign cfg_core = '{pattern: vol_pattern_register,
                      ecc: ecc_unit_status,
                      wide: wide_address_mode,
                      quad: four_lane_command_mode,
                      resume: legacy_clear_is_resume,
                      latency: read_latency};

  frcd_sync #(.W($bits(frcd_link_cfg_t))) u_cfg_sync (
    .clk(link_sclk),
    .rst(rst),
    .d(cfg_core),
    .q(cfg_l)
  );

  wire [5:0] step = cfg_l.quad ? 6'h04 : 6'h01;
  wire [31:0] sh_in = cfg_l.quad ? {sh_reg[27:0], link_io_in[3:0]} :
                                   {sh_reg[30:0], link_io_in[0]};
  wire [5:0] cnt_inc = cnt_reg + step;
  wire byte_done = (cnt_inc == BYTE_BITS);
  wire [7:0] op_now = sh_in[7:0];
  wire [5:0] abits = addr_bits(op_reg, cfg_l.wide);
  wire addr_done = (ls_reg == LS_ADDR) && (cnt_inc == abits);
  wire [31:0] addr_full = (abits == ADDR_BITS_WIDE) ? sh_in :
                          {8'h00, sh_in[23:0]};
  wire [5:0] dummy_inc = cnt_reg + 6'h01;
  wire [5:0] latency6 = {2'b00, cfg_l.latency};
  wire [3:0] obit_sum = {1'b0, obit_reg} + {1'b0, step[2:0]};
  wire out_wrap = (ls_reg == LS_OUT) && obit_sum[3];
  wire is_ecc = (op_reg == OP_ECC_READ) || (op_reg == OP_ECC_READ_WIDE);
  wire [7:0] out_byte = is_ecc ? cfg_l.ecc : cfg_l.pattern;

  always_comb begin
    ls_next = ls_reg;
    case (ls_reg)
      LS_CMD: begin
        if (byte_done) begin
          case (op_now)
            OP_LATCH_SET, OP_LATCH_CLEAR, OP_CLEAR_LEGACY, OP_CLEAR_ALT,
            OP_WIDE_ENTER: ls_next = LS_END;
            OP_NV_PROGRAM, OP_VOL_WRITE: ls_next = LS_DATA;
            OP_PATTERN_READ: ls_next = LS_OUT;
            OP_ECC_READ, OP_ECC_READ_WIDE,
            OP_PARAM_READ: ls_next = LS_ADDR;
            default: ls_next = LS_IGNORE;
          endcase
        end
      end
      LS_ADDR: begin
        if (addr_done) begin
          if (op_reg == OP_PARAM_READ)
            ls_next = LS_IGNORE;
          else if (cfg_l.latency == 4'h0)
            ls_next = LS_OUT;
          else
            ls_next = LS_DUMMY;
        end
      end
      LS_DUMMY: begin
        if (dummy_inc == latency6)
          ls_next = LS_OUT;
      end
      LS_DATA: begin
        if (byte_done)
          ls_next = LS_END;
      end
      LS_END: ls_next = LS_IGNORE;
      LS_OUT: ls_next = LS_OUT;
      LS_IGNORE: ls_next = LS_IGNORE;
      default: ls_next = LS_IGNORE;
    endcase
  end

  // the frame result only names an action while the frame stands at its
  // exact end; any further edge withdraws it
  always_comb begin
    frame_next = '{act: ACT_NONE, data: 8'h00};
    if (ls_next == LS_END) begin
      if (ls_reg == LS_CMD)
        frame_next.act = act_of(op_now, cfg_l.resume);
      else
        frame_next = '{act: act_of(op_reg, cfg_l.resume),
                       data: sh_in[7:0]};
    end
  end

  always_ff @(posedge link_sclk or posedge link_rst) begin
    if (link_rst) begin
      ls_reg <= LS_CMD;
      cnt_reg <= 6'h00;
      sh_reg <= 32'h0000_0000;
      op_reg <= 8'h00;
    end else begin
      ls_reg <= ls_next;
      sh_reg <= sh_in;
      if (ls_next != ls_reg)
        cnt_reg <= 6'h00;
      else if (ls_reg == LS_DUMMY)
        cnt_reg <= dummy_inc;
      else
        cnt_reg <= cnt_inc;
      if (ls_reg == LS_CMD && byte_done)
        op_reg <= op_now;
    end
  end

  // survives chip select high so the core can take it at frame end
  always_ff @(posedge link_sclk or posedge rst) begin
    if (rst)
      frame_reg <= '{act: ACT_NONE, data: 8'h00};
    else
      frame_reg <= frame_next;
  end

  // one toggle per clocked frame, so a chip select pulse with no clock
  // edges cannot replay the action still held in frame_reg
  logic frame_tgl_reg;

  always_ff @(posedge link_sclk or posedge rst) begin
    if (rst)
      frame_tgl_reg <= 1'b0;
    else if (ls_reg == LS_CMD && cnt_reg == 6'h00)
      frame_tgl_reg <= ~frame_tgl_reg;
  end

  always_ff @(posedge link_sclk or posedge link_rst) begin
    if (link_rst) begin
      obit_reg <= 3'h0;
      obyte_reg <= 4'h0;
    end else if (ls_reg == LS_OUT) begin
      obit_reg <= obit_sum[2:0];
      if (out_wrap)
        obyte_reg <= obyte_reg + 4'h1;
    end
  end

  // unit index kept across frames for the ecc store
  always_ff @(posedge link_sclk or posedge rst) begin
    if (rst)
      ecc_unit_index <= 28'h000_0000;
    else if (addr_done && is_ecc)
      ecc_unit_index <= addr_full[31:4];
    else if (out_wrap && is_ecc && obyte_reg == ECC_LAST_BYTE)
      ecc_unit_index <= ecc_unit_index + 28'h000_0001;
  end

  // data leaves on the falling edge so the host samples it rising
  always_ff @(negedge link_sclk or posedge link_rst) begin
    if (link_rst) begin
      link_io_out <= 8'h00;
      link_io_oe <= 8'h00;
    end else if (ls_reg == LS_OUT) begin
      if (cfg_l.quad) begin
        link_io_out <= obit_reg[2] ? {2{out_byte[3:0]}} :
                                     {2{out_byte[7:4]}};
        link_io_oe <= OE_QUAD;
      end else begin
        link_io_out <= {2{2'b00, out_byte[3'h7 - obit_reg], 1'b0}};
        link_io_oe <= OE_SINGLE;
      end
    end
  end

  // ---------------- core domain ----------------
  logic cs_sync;
  logic cs_prev_reg;
  logic latch_reg;
  logic efail_reg;
  logic pfail_reg;
  logic [7:0] prog_data_reg;
  logic [NV_TIMER_W-1:0] timer_reg;
  frcd_cstate_t cs_reg;
  logic [7:0] status_next;

  frcd_sync #(.W(1), .INIT(1'b1)) u_cs_sync (
    .clk(core_clk),
    .rst(rst),
    .d(link_cs_n),
    .q(cs_sync)
  );

  logic tgl_sync;
  logic tgl_seen_reg;

  frcd_sync #(.W(1), .INIT(1'b0)) u_tgl_sync (
    .clk(core_clk),
    .rst(rst),
    .d(frame_tgl_reg),
    .q(tgl_sync)
  );

  // frame_reg stands still once the link clock has stopped for the
  // synchronised chip select edge; a frame counts only if it toggled
  wire cs_rise = cs_sync & ~cs_prev_reg;
  wire frame_end = cs_rise & (tgl_sync != tgl_seen_reg);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      tgl_seen_reg <= 1'b0;
    else if (cs_rise)
      tgl_seen_reg <= tgl_sync;
  end
  wire frcd_act_t fr_act = frame_reg.act;
  wire [7:0] fr_data = frame_reg.data;
  wire prog_done = (cs_reg == CS_PROG) && (timer_reg == '0);
  wire busy_any = (cs_reg == CS_PROG) | ext_busy;
  wire do_lset = frame_end && fr_act == ACT_LATCH_SET;
  wire do_lclr = frame_end && fr_act == ACT_LATCH_CLEAR && !busy_any;
  wire do_clear = frame_end && fr_act == ACT_CLEAR;
  wire do_resume = frame_end && fr_act == ACT_RESUME;
  wire do_wide = frame_end && fr_act == ACT_WIDE;
  wire do_vol = frame_end && fr_act == ACT_VOL_WRITE && latch_reg;
  wire do_nv = frame_end && fr_act == ACT_NV_PROGRAM && latch_reg &&
               !busy_any;
  wire pfail_set = ext_prog_fail_set | (prog_done & nv_prog_fail);
  wire latch_next = soft_reset ? 1'b0 :
                    prog_done ? 1'b0 :
                    do_lset ? 1'b1 :
                    do_lclr ? 1'b0 : latch_reg;
  // a fail event in the clearing cycle wins over the clear
  wire pfail_next = pfail_set | (pfail_reg & ~do_clear & ~soft_reset);
  wire efail_next = ext_erase_fail_set |
                    (efail_reg & ~do_clear & ~soft_reset);
  wire busy_next = (cs_reg == CS_PROG && !prog_done) || do_nv ||
                   ext_busy;

  always_comb begin
    status_next = STATUS_ONE_RESET;
    status_next[ST1_BUSY] = busy_next;
    status_next[ST1_LATCH] = latch_next;
    status_next[ST1_ERASE_FAIL] = efail_next;
    status_next[ST1_PROG_FAIL] = pfail_next;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cs_prev_reg <= 1'b1;
      latch_reg <= 1'b0;
      efail_reg <= 1'b0;
      pfail_reg <= 1'b0;
      volatile_status_one <= STATUS_ONE_RESET;
      resume_req <= 1'b0;
    end else begin
      cs_prev_reg <= cs_sync;
      latch_reg <= latch_next;
      efail_reg <= efail_next;
      pfail_reg <= pfail_next;
      volatile_status_one <= status_next;
      resume_req <= do_resume;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      wide_address_mode <= 1'b0;
    else if (soft_reset)
      wide_address_mode <= 1'b0;
    else if (do_wide)
      wide_address_mode <= 1'b1;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      vol_pattern_register <= PATTERN_RESET;
    else if (soft_reset)
      vol_pattern_register <= PATTERN_RESET;
    else if (do_vol)
      vol_pattern_register <= fr_data;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cs_reg <= CS_IDLE;
      timer_reg <= '0;
      prog_data_reg <= 8'h00;
      nv_pattern_register <= PATTERN_RESET;
    end else begin
      case (cs_reg)
        CS_IDLE: begin
          if (do_nv) begin
            cs_reg <= CS_PROG;
            timer_reg <= NV_TIMER_W'(NV_PROG_CYCLES - 1);
            prog_data_reg <= fr_data;
          end
        end
        CS_PROG: begin
          if (prog_done) begin
            cs_reg <= CS_IDLE;
            if (!nv_prog_fail)
              nv_pattern_register <= prog_data_reg;
          end else begin
            timer_reg <= timer_reg - 1'b1;
          end
        end
        default: cs_reg <= CS_IDLE;
      endcase
    end
  end

  // ---------------- checks ----------------
  localparam int NV_WAIT = NV_PROG_CYCLES + 2;

  sequence s_nv_start;
    do_nv && !soft_reset;
  endsequence
  sequence s_nv_hold;
    volatile_status_one[ST1_BUSY] [*8];
  endsequence

  property p_latch_set;
    @(posedge core_clk) disable iff (rst)
    do_lset && !soft_reset && !prog_done
      |=> ##1 volatile_status_one[ST1_LATCH];
  endproperty
  a_latch_set: assert property (p_latch_set)
    else $error("latch set opcode did not set latch");

  property p_latch_clear;
    @(posedge core_clk) disable iff (rst)
    do_lclr && !do_lset |=> ##1 !volatile_status_one[ST1_LATCH];
  endproperty
  a_latch_clear: assert property (p_latch_clear)
    else $error("latch clear opcode did not clear latch");

  property p_clear_busy;
    @(posedge core_clk) disable iff (rst)
    frame_end && fr_act == ACT_LATCH_CLEAR && busy_any && latch_reg &&
    !prog_done && !soft_reset |=> latch_reg;
  endproperty
  a_clear_busy: assert property (p_clear_busy)
    else $error("latch clear acted while busy");

  property p_status_clear;
    @(posedge core_clk) disable iff (rst)
    do_clear && !pfail_set && !ext_erase_fail_set && !soft_reset
      |=> !pfail_reg && !efail_reg && $stable(latch_reg) ||
          $past(prog_done);
  endproperty
  a_status_clear: assert property (p_status_clear)
    else $error("clear status left a fail flag or moved latch");

  property p_nv_busy;
    @(posedge core_clk) disable iff (rst)
    s_nv_start |=> ##1 s_nv_hold;
  endproperty
  a_nv_busy: assert property (p_nv_busy)
    else $error("busy not held during pattern program");

  property p_nv_done;
    @(posedge core_clk) disable iff (rst)
    s_nv_start |-> ##[1:NV_WAIT] prog_done;
  endproperty
  a_nv_done: assert property (p_nv_done)
    else $error("pattern program did not finish in time");

  property p_nv_latch;
    @(posedge core_clk) disable iff (rst)
    prog_done |=> !latch_reg;
  endproperty
  a_nv_latch: assert property (p_nv_latch)
    else $error("latch survived pattern program end");

  property p_vol_write;
    @(posedge core_clk) disable iff (rst)
    do_vol && !soft_reset |=> vol_pattern_register == $past(fr_data);
  endproperty
  a_vol_write: assert property (p_vol_write)
    else $error("volatile pattern not written");

  property p_no_latch;
    @(posedge core_clk) disable iff (rst)
    frame_end && fr_act == ACT_VOL_WRITE && !latch_reg && !soft_reset
      |=> $stable(vol_pattern_register);
  endproperty
  a_no_latch: assert property (p_no_latch)
    else $error("pattern written without latch");

  property p_wide_sticky;
    @(posedge core_clk) disable iff (rst)
    wide_address_mode && !soft_reset |=> wide_address_mode;
  endproperty
  a_wide_sticky: assert property (p_wide_sticky)
    else $error("wide address mode left without reset");

  property p_abort;
    @(posedge link_sclk) disable iff (link_rst)
      ls_reg == LS_END |=> frame_reg.act == ACT_NONE;
  endproperty
  a_abort: assert property (p_abort)
    else $error("overlong frame kept its action");
endmodule
`default_nettype wire

// [bench/frcd_host.sv]
// host controller model: drives chip select, serial clock and io lanes
// assumes spi mode 0, clock idle low and stopped between frames
`timescale 1ns/100ps
`default_nettype none
module frcd_host (
  // serial link toward the decoder
  output logic link_sclk,
  output logic link_cs_n,
  output logic [7:0] link_io_in,
  input wire logic [7:0] link_io_out,
  input wire logic [7:0] link_io_oe
);
  localparam time HALF = 32;
  // output enables seen at the last rising edge of the last frame
  logic [7:0] oe_seen = 8'h00;

  initial begin
    link_sclk = 1'b0;
    link_cs_n = 1'b1;
    link_io_in = 8'h5a;
  end

  // shifts out the low nbits of tx and returns what came back on io1, or on io3..io0 in quad
  task automatic xfer(input logic [63:0] tx, input int nbits,
                      input bit quad, output logic [63:0] rx);
    int i;
    int step;
    step = quad ? 4 : 1;
    rx = '0;
    link_cs_n = 1'b0;
    for (i = nbits - step; i >= 0; i -= step) begin
      if (quad) begin
        link_io_in = {2{tx[i +: 4]}};
      end else begin
        link_io_in = {3'b000, tx[i], 3'b000, tx[i]};
      end
      #HALF;
      link_sclk = 1'b1;
      rx = quad ? {rx[59:0], link_io_out[3:0]} : {rx[62:0], link_io_out[1]};
      oe_seen = link_io_oe;
      #HALF;
      link_sclk = 1'b0;
    end
    #HALF;
    // chip select rises half a clock after the last of the nbits bits
    link_cs_n = 1'b1;
    // released lanes must not keep showing the last value
    link_io_in = ~link_io_in;
  endtask
endmodule
`default_nettype wire

// [bench/testbench.sv]
// self-checking bench of the command decoder against a small model
// assumes the host model above as far side and a 100 MHz core clock
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, a, e); end end
module testbench;
  import frcd_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic four_lane_command_mode = 1'b0;
  logic legacy_clear_is_resume = 1'b0;
  logic [3:0] read_latency = 4'h2;
  logic soft_reset = 1'b0;
  logic ext_busy = 1'b0;
  logic ext_prog_fail_set = 1'b0;
  logic ext_erase_fail_set = 1'b0;
  logic nv_prog_fail = 1'b0;
  logic [7:0] ecc_unit_status = 8'h00;
  wire logic link_sclk;
  wire logic link_cs_n;
  wire logic [7:0] link_io_in;
  wire logic [7:0] link_io_out;
  wire logic [7:0] link_io_oe;
  wire logic [7:0] volatile_status_one;
  wire logic wide_address_mode;
  wire logic [7:0] vol_pattern_register;
  wire logic [7:0] nv_pattern_register;
  wire logic resume_req;
  wire logic [27:0] ecc_unit_index;
  int err_total = 0;
  int cmp_count = 0;
  int resume_seen = 0;
  logic [31:0] seed = 32'd64086;
  bit quad = 1'b0;
  bit m_latch, m_busy, m_ef, m_pf, m_wide;
  logic [7:0] m_vp = 8'h00;
  logic [7:0] m_np = 8'h00;
  logic [7:0] d;
  logic [63:0] rx;
  int k;

  always #5 core_clk = ~core_clk;

  frcd_decoder i_frcd_decoder (.core_clk(core_clk), .rst(rst),
    .link_sclk(link_sclk), .link_cs_n(link_cs_n), .link_io_in(link_io_in),
    .link_io_out(link_io_out), .link_io_oe(link_io_oe),
    .four_lane_command_mode(four_lane_command_mode),
    .legacy_clear_is_resume(legacy_clear_is_resume),
    .read_latency(read_latency), .soft_reset(soft_reset),
    .ext_busy(ext_busy), .ext_prog_fail_set(ext_prog_fail_set),
    .ext_erase_fail_set(ext_erase_fail_set), .nv_prog_fail(nv_prog_fail),
    .ecc_unit_status(ecc_unit_status),
    .volatile_status_one(volatile_status_one),
    .wide_address_mode(wide_address_mode),
    .vol_pattern_register(vol_pattern_register),
    .nv_pattern_register(nv_pattern_register), .resume_req(resume_req),
    .ecc_unit_index(ecc_unit_index));

  frcd_host i_frcd_host (.link_sclk(link_sclk), .link_cs_n(link_cs_n),
    .link_io_in(link_io_in), .link_io_out(link_io_out),
    .link_io_oe(link_io_oe));

  always @(posedge core_clk) begin
    if (resume_req === 1'b1) begin
      resume_seen++;
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // one frame, then room for the status effect to land
  task automatic cmd(input logic [63:0] tx, input int n);
    logic [63:0] r;
    i_frcd_host.xfer(tx, n, quad, r);
    repeat (10) @(posedge core_clk);
  endtask

  task automatic check_st();
    `CHK(volatile_status_one, {1'b0, m_pf, m_ef, 3'b000, m_latch, m_busy})
    `CHK(wide_address_mode, m_wide)
    `CHK(vol_pattern_register, m_vp)
    `CHK(nv_pattern_register, m_np)
  endtask

  task automatic set_fails();
    @(posedge core_clk);
    ext_prog_fail_set <= 1'b1;
    ext_erase_fail_set <= 1'b1;
    @(posedge core_clk);
    ext_prog_fail_set <= 1'b0;
    ext_erase_fail_set <= 1'b0;
    m_pf = 1'b1;
    m_ef = 1'b1;
    repeat (3) @(posedge core_clk);
  endtask

  // ecc read of two bytes; abits is the address length the host sends
  task automatic ecc_read(input logic [7:0] op, input int abits);
    logic [63:0] t;
    int lat;
    lat = read_latency;
    t = (abits == 32) ? {24'h0, op, 32'h0000_0100} : {32'h0, op, 24'h00_0100};
    t = t << (lat + 16);
    i_frcd_host.xfer(t, 8 + abits + lat + 16, 1'b0, rx);
    `CHK(rx[15:0], {2{ecc_unit_status}})
    `CHK(ecc_unit_index, 28'h000_0010)
    repeat (10) @(posedge core_clk);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #200_000;
    err_total++;
    $display("ERROR t=%0t watchdog expired", $time);
    results();
  end

  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    ecc_unit_status <= 8'(rnd());
    repeat (5) @(posedge core_clk);
    check_st();
    cmd(OP_LATCH_SET, 8);
    m_latch = 1'b1;
    check_st();
    cmd(OP_LATCH_CLEAR, 8);
    m_latch = 1'b0;
    check_st();
    cmd({OP_LATCH_SET, 2'b00}, 10);
    check_st();
    d = 8'(rnd());
    cmd({OP_VOL_WRITE, d}, 16);
    check_st();
    cmd(OP_LATCH_SET, 8);
    m_latch = 1'b1;
    cmd({OP_VOL_WRITE, d}, 16);
    m_vp = d;
    check_st();
    i_frcd_host.xfer({OP_PATTERN_READ, 16'h0}, 24, 1'b0, rx);
    `CHK(rx[15:0], {2{m_vp}})
    `CHK(i_frcd_host.oe_seen, OE_SINGLE)
    repeat (10) @(posedge core_clk);
    set_fails();
    d = 8'(rnd());
    cmd({OP_NV_PROGRAM, d}, 16);
    m_busy = 1'b1;
    check_st();
    cmd(OP_LATCH_CLEAR, 8);
    check_st();
    cmd(OP_CLEAR_ALT, 8);
    m_pf = 1'b0;
    m_ef = 1'b0;
    check_st();
    repeat (200) @(posedge core_clk);
    m_busy = 1'b0;
    m_latch = 1'b0;
    m_np = d;
    check_st();
    for (k = 0; k < 2; k++) begin
      set_fails();
      legacy_clear_is_resume <= k[0];
      repeat (2) @(posedge core_clk);
      cmd(OP_CLEAR_LEGACY, 8);
      if (k == 0) begin
        m_pf = 1'b0;
        m_ef = 1'b0;
      end
      check_st();
    end
    // a chip select pulse with no clocks must not replay the resume
    cmd(8'h00, 0);
    `CHK(resume_seen, 1)
    cmd(OP_WIDE_ENTER, 8);
    m_wide = 1'b1;
    check_st();
    cmd(OP_LATCH_CLEAR, 8);
    check_st();
    ecc_read(OP_ECC_READ, 32);
    @(posedge core_clk);
    soft_reset <= 1'b1;
    @(posedge core_clk);
    soft_reset <= 1'b0;
    repeat (5) @(posedge core_clk);
    {m_wide, m_pf, m_ef, m_latch, m_vp} = '0;
    check_st();
    read_latency <= 4'h0;
    repeat (2) @(posedge core_clk);
    ecc_read(OP_ECC_READ, 24);
    ecc_read(OP_ECC_READ_WIDE, 32);
    four_lane_command_mode <= 1'b1;
    repeat (2) @(posedge core_clk);
    cmd(8'h00, 2);
    quad = 1'b1;
    cmd(OP_LATCH_SET, 8);
    m_latch = 1'b1;
    check_st();
    results();
  end
endmodule
`default_nettype wire
